// file: verilog/casx_consts.vh
// Constants for the architectural state block: register map, field
// positions, reset values. Included by name by the core state design file only.
`ifndef CASX_CONSTS_VH
`define CASX_CONSTS_VH

`define CASX_REG_CTRL      6'h00
`define CASX_REG_SHADOW    6'h01
`define CASX_REG_IRQ_STAT  6'h02
`define CASX_REG_IRQ_MASK  6'h03
`define CASX_REG_PC        6'h04
`define CASX_REG_LINK      6'h05
`define CASX_REG_EXC_INFO  6'h06
`define CASX_REG_FLAGS     6'h07
`define CASX_REG_EXC_ARG   6'h08

`define CASX_CTRL_FLIP     0
`define CASX_CTRL_FR       1
`define CASX_CTRL_RESET    2'h0

`define CASX_EV_W          3

`define CASX_PC_RESET      32'hbfc00000
`define CASX_EXC_VECTOR    32'h80000180
`define CASX_INC_COMPACT   32'h00000002
`define CASX_INC_FULL      32'h00000004
`define CASX_LINK_REG      5'h1f

`endif

// file: verilog/casx_regfile.v
// Banked general register file with two write ports and two read ports.
// Assumes the caller gives the bank in the upper address bits.
`timescale 1ns/100ps
module casx_regfile #(
    parameter SET_BITS = 2
) (
    input  wire                  clk_i,
    input  wire                  we_a_i,
    input  wire [SET_BITS+4:0]   wa_a_i,
    input  wire [31:0]           wd_a_i,
    input  wire                  we_b_i,
    input  wire [SET_BITS+4:0]   wa_b_i,
    input  wire [31:0]           wd_b_i,
    input  wire [SET_BITS+4:0]   ra_a_i,
    input  wire [SET_BITS+4:0]   ra_b_i,
    output reg  [31:0]           rd_a_o,
    output reg  [31:0]           rd_b_o
);
    reg [31:0] mem [0:(32<<SET_BITS)-1];

    // Port a wins when both write one entry in the same cycle
    always @(posedge clk_i) begin
        if (we_b_i && !(we_a_i && wa_a_i == wa_b_i)) begin
            mem[wa_b_i] <= wd_b_i;
        end
        if (we_a_i) begin
            mem[wa_a_i] <= wd_a_i;
        end
        rd_a_o <= (ra_a_i[4:0] == 5'h00) ? 32'h00000000 : mem[ra_a_i];
        rd_b_o <= (ra_b_i[4:0] == 5'h00) ? 32'h00000000 : mem[ra_b_i];
    end
endmodule // casx_regfile

// file: verilog/casx_xlat.v
// Register number translation for the compact instruction set.
// Assumes compact numbers sit in the low three bits of the field.
`timescale 1ns/100ps
module casx_xlat (
    input  wire [4:0] num_a_i,
    input  wire       cmp_a_i,
    input  wire [4:0] num_b_i,
    input  wire       cmp_b_i,
    output wire [4:0] idx_a_o,
    output wire [4:0] idx_b_o
);
    // Compact 0 and 1 name the two argument-free saved registers
    function [4:0] xlat;
        input [4:0] n;
        input       c;
        begin
            if (!c) begin
                xlat = n;
            end else if (n[2:1] == 2'b00) begin
                xlat = {4'h8, n[0]};
            end else begin
                xlat = {2'b00, n[2:0]};
            end
        end
    endfunction

    assign idx_a_o = xlat(num_a_i, cmp_a_i);
    assign idx_b_o = xlat(num_b_i, cmp_b_i);
endmodule // casx_xlat

// file: verilog/casx_core_state.v
// Architectural state of a processor core: banked registers, program
// counter, mode bits, endianness, link flag, exception entry.
// Assumes one retire strobe per instruction and a single AHB-Lite master.
`timescale 1ns/100ps
`include "casx_consts.vh"

// Functional notes
// - register zero always reads zero
// - register access uses current shadow set
// - memory endianness caught at reset
// - load/store endian is memory xor flip
// - flip only with bit set in user
// - pc steps 2 compact, else 4
// - one-bit instruction set mode kept
// - link and exception save pc plus mode
// - pc held as full 32 bits
// - slot flag only for real slot
// - exception abandons instruction, reports type, argument
// - link flag set, tested, cleared
// - late effects join next instruction's effects
// - fpr width mode from select bit
// - condition code zero follows coprocessor signal
// - compact register numbers translated first
// - no state hangs; reset recovers
module casx_core_state #(
    parameter SET_BITS = 2
) (
    input  wire                CLOCK_I,
    input  wire                RESET_I,
    input  wire                MEM_BIG_STRAP_I,
    input  wire                USER_MODE_I,
    input  wire                COPROC_COND_I,
    input  wire [7:0]          FCC_I,
    input  wire                ATOMIC_BREAK_I,
    input  wire                RETIRE_I,
    input  wire                RET_COMPACT_I,
    input  wire                RET_PC_SET_I,
    input  wire [31:0]         RET_PC_VAL_I,
    input  wire                RET_BRANCH_I,
    input  wire                RET_LINK_I,
    input  wire                RET_WR_EN_I,
    input  wire [4:0]          RET_WR_ADDR_I,
    input  wire                RET_WR_COMPACT_I,
    input  wire [31:0]         RET_WR_DATA_I,
    input  wire                RET_LATE_I,
    input  wire                RET_LL_I,
    input  wire                RET_SC_I,
    input  wire                EXC_I,
    input  wire [4:0]          EXC_TYPE_I,
    input  wire [31:0]         EXC_ARG_I,
    input  wire [4:0]          RD_A_ADDR_I,
    input  wire                RD_A_COMPACT_I,
    input  wire [4:0]          RD_B_ADDR_I,
    input  wire                RD_B_COMPACT_I,
    output wire [31:0]         RD_A_DATA_O,
    output wire [31:0]         RD_B_DATA_O,
    output reg  [31:0]         PC_O,
    output reg                 INSTR_SET_SELECT_O,
    output reg                 IN_SLOT_O,
    output reg                 LINK_FLAG_O,
    output reg                 SC_OK_O,
    output reg                 MEM_BIG_O,
    output reg                 ENDIAN_FLIP_O,
    output reg                 LS_BIG_O,
    output reg                 FPR_WIDE_O,
    output reg  [7:0]          FCC_O,
    output reg                 EXC_O,
    output reg  [4:0]          EXC_TYPE_O,
    output reg  [31:0]         EXC_ARG_O,
    output reg  [31:0]         EXC_EPC_O,
    output wire                IRQ_O,
    input  wire                HSEL_I,
    input  wire [31:0]         HADDR_I,
    input  wire [1:0]          HTRANS_I,
    input  wire                HWRITE_I,
    input  wire [2:0]          HSIZE_I,
    input  wire [31:0]         HWDATA_I,
    input  wire                HREADY_I,
    output wire                HREADYOUT_O,
    output wire                HRESP_O,
    output reg  [31:0]         HRDATA_O
);
    localparam ST_RUN  = 2'b01;
    localparam ST_SLOT = 2'b10;

    reg  [1:0]            state_q;
    reg  [1:0]            state_d;
    reg  [31:0]           target_q;
    reg  [1:0]            ctrl_q;
    reg  [SET_BITS-1:0]   shadow_q;
    reg  [`CASX_EV_W-1:0] irq_stat_q;
    reg  [`CASX_EV_W-1:0] irq_mask_q;
    reg  [31:0]           link_val_q;
    reg                   strap_done_q;
    reg                   late_en_q;
    reg  [4:0]            late_addr_q;
    reg  [31:0]           late_data_q;
    reg                   wr_pend_q;
    reg                   rd_pend_q;
    reg  [5:0]            dp_addr_q;
    wire [4:0]            wr_idx;
    wire [4:0]            rd_a_idx;
    wire [4:0]            rd_b_idx;
    wire [4:0]            rd_b_raw;
    wire [31:0]           pc_inc;
    wire [31:0]           pc_seq;
    wire [31:0]           link_next;
    wire                  ret_ok;
    wire                  ret_exc;
    wire                  sc_fail;
    wire                  link_lost;
    wire [`CASX_EV_W-1:0] events;
    wire                  ap_take;
    wire                  reg_wr;
    reg  [31:0]           rd_mux;

    // an exception suppresses the instruction's own effects
    assign ret_exc = RETIRE_I & EXC_I;
    assign ret_ok  = RETIRE_I & ~EXC_I;

    assign pc_inc = RET_COMPACT_I ? `CASX_INC_COMPACT : `CASX_INC_FULL;
    assign pc_seq = PC_O + pc_inc;
    // return address with the mode in bit zero
    assign link_next = {pc_seq[31:1] + pc_inc[31:1], INSTR_SET_SELECT_O};

    assign sc_fail   = ret_ok & RET_SC_I & ~LINK_FLAG_O;
    assign link_lost = LINK_FLAG_O & (ATOMIC_BREAK_I | ret_exc);
    assign events    = {link_lost, sc_fail, ret_exc};
    assign IRQ_O     = |(irq_stat_q & irq_mask_q);

    casx_xlat u_xlat (
        .num_a_i (RET_WR_ADDR_I),
        .cmp_a_i (RET_WR_COMPACT_I),
        .num_b_i (RD_A_ADDR_I),
        .cmp_b_i (RD_A_COMPACT_I),
        .idx_a_o (wr_idx),
        .idx_b_o (rd_a_idx)
    );

    // Second read port uses side a of its own instance; side b is tied off and unused
    casx_xlat u_xlat_b (
        .num_a_i (RD_B_ADDR_I),
        .cmp_a_i (RD_B_COMPACT_I),
        .num_b_i (5'h00),
        .cmp_b_i (1'b0),
        .idx_a_o (rd_b_idx),
        .idx_b_o (rd_b_raw)
    );

    // bank chosen by the shadow set field
    // late write lands with the next instruction; port a wins
    casx_regfile #(
        .SET_BITS (SET_BITS)
    ) u_rf (
        .clk_i  (CLOCK_I),
        .we_a_i (ret_ok & (RET_LINK_I | (RET_WR_EN_I & ~RET_LATE_I))),
        .wa_a_i ({shadow_q, RET_LINK_I ? `CASX_LINK_REG : wr_idx}),
        .wd_a_i (RET_LINK_I ? link_next : RET_WR_DATA_I),
        .we_b_i (RETIRE_I & late_en_q),
        .wa_b_i ({shadow_q, late_addr_q}),
        .wd_b_i (late_data_q),
        .ra_a_i ({shadow_q, rd_a_idx}),
        .ra_b_i ({shadow_q, rd_b_idx}),
        .rd_a_o (RD_A_DATA_O),
        .rd_b_o (RD_B_DATA_O)
    );

    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            late_en_q   <= 1'b0;
            late_addr_q <= 5'h00;
            late_data_q <= 32'h00000000;
        end else if (RETIRE_I) begin
            late_en_q   <= ret_ok & RET_WR_EN_I & RET_LATE_I;
            late_addr_q <= wr_idx;
            late_data_q <= RET_WR_DATA_I;
        end
    end

    // strap caught on the first edge after release
    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            strap_done_q <= 1'b0;
            MEM_BIG_O    <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            MEM_BIG_O    <= MEM_BIG_STRAP_I;
        end
    end

    // flip and derived modes follow every change
    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ENDIAN_FLIP_O <= 1'b0;
            LS_BIG_O      <= 1'b0;
            FPR_WIDE_O    <= 1'b0;
            FCC_O         <= 8'h00;
        end else begin
            ENDIAN_FLIP_O <= ctrl_q[`CASX_CTRL_FLIP] & USER_MODE_I;
            LS_BIG_O      <= MEM_BIG_O ^
                             (ctrl_q[`CASX_CTRL_FLIP] & USER_MODE_I);
            FPR_WIDE_O    <= ctrl_q[`CASX_CTRL_FR];
            FCC_O         <= {FCC_I[7:1], COPROC_COND_I};
        end
    end

    // slot state comes from execution order, not address
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (ret_ok && RET_BRANCH_I) begin
                    state_d = ST_SLOT;
                end
            end
            ST_SLOT: begin
                if (RETIRE_I) begin
                    state_d = ST_RUN;
                end
            end
            // stray code falls back to run
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_q    <= ST_RUN;
            PC_O       <= `CASX_PC_RESET;
            INSTR_SET_SELECT_O <= 1'b0;
            IN_SLOT_O  <= 1'b0;
            target_q   <= `CASX_PC_RESET;
            link_val_q <= 32'h00000000;
            EXC_O      <= 1'b0;
            EXC_TYPE_O <= 5'h00;
            EXC_ARG_O  <= 32'h00000000;
            EXC_EPC_O  <= 32'h00000000;
        end else begin
            state_q <= ret_exc ? ST_RUN : state_d;
            EXC_O   <= ret_exc;
            if (ret_exc) begin
                // report type and argument, go to vector
                EXC_TYPE_O <= EXC_TYPE_I;
                EXC_ARG_O  <= EXC_ARG_I;
                EXC_EPC_O  <= {PC_O[31:1], INSTR_SET_SELECT_O};
                PC_O       <= `CASX_EXC_VECTOR;
                INSTR_SET_SELECT_O <= 1'b0;
                IN_SLOT_O  <= 1'b0;
            end else if (ret_ok) begin
                IN_SLOT_O <= (state_q == ST_RUN) & RET_BRANCH_I;
                if (RET_LINK_I) begin
                    link_val_q <= link_next;
                end
                if (RET_BRANCH_I && state_q == ST_RUN) begin
                    // Target waits until the slot instruction retires
                    target_q <= RET_PC_SET_I ? RET_PC_VAL_I : pc_seq + pc_inc;
                    PC_O     <= pc_seq;
                end else if (state_q == ST_SLOT) begin
                    // target bit zero selects the mode
                    PC_O       <= {target_q[31:1], 1'b0};
                    INSTR_SET_SELECT_O <= target_q[0];
                end else if (RET_PC_SET_I) begin
                    PC_O       <= {RET_PC_VAL_I[31:1], 1'b0};
                    INSTR_SET_SELECT_O <= RET_PC_VAL_I[0];
                end else begin
                    PC_O <= pc_seq;
                end
            end
        end
    end

    // set by load-linked, cleared by exceptions, breaks or store-conditional
    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            LINK_FLAG_O <= 1'b0;
            SC_OK_O     <= 1'b0;
        end else begin
            if (ret_ok && RET_SC_I) begin
                SC_OK_O <= LINK_FLAG_O & ~ATOMIC_BREAK_I;
            end
            if (ret_exc || ATOMIC_BREAK_I || (ret_ok && RET_SC_I)) begin
                LINK_FLAG_O <= 1'b0;
            end else if (ret_ok && RET_LL_I) begin
                LINK_FLAG_O <= 1'b1;
            end
        end
    end

    // Bus slave: writes zero-wait, reads take one wait state so that a
    // write just before is already visible
    assign ap_take     = HSEL_I & HREADY_I & HTRANS_I[1];
    assign HREADYOUT_O = ~rd_pend_q;
    assign HRESP_O     = 1'b0;
    assign reg_wr      = wr_pend_q & HREADY_I;

    always @* begin
        rd_mux = 32'h00000000;
        case (dp_addr_q)
            `CASX_REG_CTRL:     rd_mux = {30'h0, ctrl_q};
            `CASX_REG_SHADOW:   rd_mux = {{(32-SET_BITS){1'b0}}, shadow_q};
            `CASX_REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
            `CASX_REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_q};
            `CASX_REG_PC:       rd_mux = PC_O;
            `CASX_REG_LINK:     rd_mux = link_val_q;
            `CASX_REG_EXC_INFO: rd_mux = {27'h0, EXC_TYPE_O};
            `CASX_REG_EXC_ARG:  rd_mux = EXC_ARG_O;
            `CASX_REG_FLAGS:    rd_mux = {24'h0, FCC_O[0], FPR_WIDE_O,
                                          INSTR_SET_SELECT_O, IN_SLOT_O,
                                          LINK_FLAG_O, ENDIAN_FLIP_O,
                                          LS_BIG_O, MEM_BIG_O};
            default:            rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            dp_addr_q <= 6'h00;
            HRDATA_O  <= 32'h00000000;
        end else begin
            if (rd_pend_q) begin
                HRDATA_O <= rd_mux;
            end
            rd_pend_q <= ap_take & ~HWRITE_I;
            if (HREADY_I) begin
                wr_pend_q <= ap_take & HWRITE_I;
            end
            if (ap_take) begin
                dp_addr_q <= HADDR_I[7:2];
            end
        end
    end

    // Status set wins over a write-one clear in the same cycle
    always @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ctrl_q     <= `CASX_CTRL_RESET;
            shadow_q   <= {SET_BITS{1'b0}};
            irq_mask_q <= {`CASX_EV_W{1'b0}};
            irq_stat_q <= {`CASX_EV_W{1'b0}};
        end else begin
            if (reg_wr && dp_addr_q == `CASX_REG_CTRL) begin
                ctrl_q <= HWDATA_I[1:0];
            end
            if (reg_wr && dp_addr_q == `CASX_REG_SHADOW) begin
                shadow_q <= HWDATA_I[SET_BITS-1:0];
            end
            if (reg_wr && dp_addr_q == `CASX_REG_IRQ_MASK) begin
                irq_mask_q <= HWDATA_I[`CASX_EV_W-1:0];
            end
            if (reg_wr && dp_addr_q == `CASX_REG_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~HWDATA_I[`CASX_EV_W-1:0])
                              | events;
            end else begin
                irq_stat_q <= irq_stat_q | events;
            end
        end
    end
endmodule // casx_core_state

// file: bench/casx_core_state_props.sv
// Concurrent checks on the ports of the core state block.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
module casx_core_state_props (
    input        CLOCK_I,
    input        RESET_I,
    input        RETIRE_I,
    input        EXC_I,
    input        RET_PC_SET_I,
    input        RET_COMPACT_I,
    input        RET_BRANCH_I,
    input        RET_LL_I,
    input        ATOMIC_BREAK_I,
    input        USER_MODE_I,
    input        COPROC_COND_I,
    input [4:0]  EXC_TYPE_I,
    input [4:0]  RD_A_ADDR_I,
    input        RD_A_COMPACT_I,
    input [31:0] RD_A_DATA_O,
    input [31:0] PC_O,
    input        INSTR_SET_SELECT_O,
    input        IN_SLOT_O,
    input        LINK_FLAG_O,
    input        MEM_BIG_O,
    input        ENDIAN_FLIP_O,
    input        LS_BIG_O,
    input [7:0]  FCC_O,
    input        EXC_O,
    input [4:0]  EXC_TYPE_O,
    input [31:0] EXC_EPC_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    sequence s_exc;
        RETIRE_I && EXC_I;
    endsequence
    sequence s_branch;
        RETIRE_I && RET_BRANCH_I && !EXC_I && !IN_SLOT_O;
    endsequence

    a_zero_reg: assert property (
        RD_A_ADDR_I == 5'h00 && !RD_A_COMPACT_I |=> RD_A_DATA_O == 32'h0)
        else $error("zero reg nonzero");
    a_mem_fixed: assert property (
        !$past(RESET_I) && !$past(RESET_I, 2) |-> $stable(MEM_BIG_O))
        else $error("mem endian moved");
    a_ls_xor: assert property (
        LS_BIG_O == ($past(MEM_BIG_O) ^ ENDIAN_FLIP_O))
        else $error("ls endian wrong");
    a_flip_user: assert property (
        !$past(USER_MODE_I) |-> !ENDIAN_FLIP_O)
        else $error("flip outside user");
    a_pc_step: assert property (
        RETIRE_I && !EXC_I && !RET_PC_SET_I && !IN_SLOT_O |=>
        PC_O - $past(PC_O) == ($past(RET_COMPACT_I) ? 32'h2 : 32'h4))
        else $error("pc step wrong");
    a_exc_save: assert property (
        s_exc |=> EXC_TYPE_O == $past(EXC_TYPE_I) &&
        EXC_EPC_O == (($past(PC_O) & ~32'h1) | $past(INSTR_SET_SELECT_O)))
        else $error("epc wrong");
    a_slot_flag: assert property (
        s_branch |=> IN_SLOT_O)
        else $error("slot flag missing");
    a_exc_entry: assert property (
        s_exc |=> EXC_O && PC_O == 32'h80000180 && !INSTR_SET_SELECT_O)
        else $error("exc entry wrong");
    a_exc_cause: assert property (
        EXC_O |-> $past(RETIRE_I) && $past(EXC_I))
        else $error("exc without cause");
    a_link_set: assert property (
        RETIRE_I && RET_LL_I && !EXC_I && !ATOMIC_BREAK_I |=> LINK_FLAG_O)
        else $error("link flag not set");
    a_link_drop: assert property (
        s_exc |=> !LINK_FLAG_O)
        else $error("link kept on exc");
    a_fcc_zero: assert property (
        !$past(RESET_I) |-> FCC_O[0] == $past(COPROC_COND_I))
        else $error("fcc0 wrong");
endmodule // casx_core_state_props

bind casx_core_state casx_core_state_props u_props (.*);

// file: bench/casx_instr_src.sv
// Instruction stream model: one retire record per call of ret.
// Assumes ret is entered just after a rising clock edge.
`timescale 1ns/100ps
module casx_instr_src (
    input  wire        clk_i,
    output reg         retire_o = 1'b0,
    output reg  [9:0]  flags_o  = 10'h000,
    output reg  [31:0] pc_val_o = 32'h0,
    output reg  [4:0]  num_o    = 5'h00,
    output reg  [31:0] data_o   = 32'h0
);
    // Inverse when idle so stale fields never look valid
    task ret(input [9:0] f, input [31:0] v, input [4:0] n,
             input [31:0] d);
        begin
            retire_o <= 1'b1;
            flags_o  <= f;
            pc_val_o <= v;
            num_o    <= n;
            data_o   <= d;
            @(posedge clk_i);
            retire_o <= 1'b0;
            flags_o  <= ~f;
            pc_val_o <= ~v;
            num_o    <= ~n;
            data_o   <= ~d;
            @(posedge clk_i);
        end
    endtask
endmodule // casx_instr_src

// file: bench/test_casx_core_state.sv
// Self-checking bench for the core state block.
// Assumes a single 10 MHz clock and the instruction stream model.
`timescale 1ns/100ps
`define CHK(g, e, n) begin total_checks++; if ((g) !== (e)) begin \
    num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module test_casx_core_state;
    localparam F_CMP = 10'h001, F_PCS = 10'h002, F_BR = 10'h004;
    localparam F_LNK = 10'h008, F_WEN = 10'h010, F_WCM = 10'h020;
    localparam F_LATE = 10'h040, F_LL = 10'h080, F_SC = 10'h100;
    localparam F_EXC = 10'h200;
    reg         clk = 1'b0, rst = 1'b1, strap = 1'b1, user = 1'b0;
    reg         cop = 1'b0, brk = 1'b0, rd_cmp = 1'b0, hwrite = 1'b0;
    reg  [7:0]  fcc = 8'h00;
    reg  [4:0]  rd_num = 5'h00;
    reg  [1:0]  htrans = 2'h0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0;
    reg  [31:0] pc_e = 32'hbfc00000, epc, tgt, lnk, rv;
    reg         isa_e = 1'b0, pend = 1'b0;
    integer     num_errors = 0, total_checks = 0;
    wire        retire, hrdy, irq, isa, slot, link, sc_ok, exc;
    wire        mem_big, flip, ls_big, wide;
    wire [9:0]  fl;
    wire [4:0]  num, exc_type;
    wire [7:0]  fcc_o;
    wire [31:0] pcv, dat, rda, rdb, pc, hrdata, exc_arg, exc_epc;

    always #50 clk = ~clk;

    casx_instr_src src (.clk_i(clk), .retire_o(retire), .flags_o(fl),
        .pc_val_o(pcv), .num_o(num), .data_o(dat));

    casx_core_state dut (
        .CLOCK_I(clk), .RESET_I(rst), .MEM_BIG_STRAP_I(strap),
        .USER_MODE_I(user), .COPROC_COND_I(cop), .FCC_I(fcc),
        .ATOMIC_BREAK_I(brk), .RETIRE_I(retire),
        .RET_COMPACT_I(fl[0]), .RET_PC_SET_I(fl[1]),
        .RET_BRANCH_I(fl[2]), .RET_LINK_I(fl[3]), .RET_WR_EN_I(fl[4]),
        .RET_WR_COMPACT_I(fl[5]), .RET_LATE_I(fl[6]), .RET_LL_I(fl[7]),
        .RET_SC_I(fl[8]), .EXC_I(fl[9]), .RET_PC_VAL_I(pcv),
        .RET_WR_ADDR_I(num), .RET_WR_DATA_I(dat), .EXC_TYPE_I(num),
        .EXC_ARG_I(dat), .RD_A_ADDR_I(rd_num), .RD_A_COMPACT_I(rd_cmp),
        .RD_B_ADDR_I(rd_num), .RD_B_COMPACT_I(rd_cmp),
        .RD_A_DATA_O(rda), .RD_B_DATA_O(rdb), .PC_O(pc),
        .INSTR_SET_SELECT_O(isa), .IN_SLOT_O(slot), .LINK_FLAG_O(link),
        .SC_OK_O(sc_ok), .MEM_BIG_O(mem_big), .ENDIAN_FLIP_O(flip),
        .LS_BIG_O(ls_big), .FPR_WIDE_O(wide), .FCC_O(fcc_o),
        .EXC_O(exc), .EXC_TYPE_O(exc_type), .EXC_ARG_O(exc_arg),
        .EXC_EPC_O(exc_epc), .IRQ_O(irq), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
        .HREADYOUT_O(hrdy), .HRESP_O(), .HRDATA_O(hrdata));

    task close_out;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // Waits as long as the slave stretches
    task xfer(input [31:0] a, input w, input [31:0] wd,
              output [31:0] d);
        begin
            htrans <= 2'h2;
            haddr  <= a;
            hwrite <= w;
            do @(posedge clk); while (hrdy !== 1'b1);
            htrans <= 2'h0;
            hwdata <= wd;
            do @(posedge clk); while (hrdy !== 1'b1);
            d = hrdata;
        end
    endtask

    task rdc(input [31:0] a, input [31:0] m, input [31:0] e);
        begin
            xfer(a, 1'b0, 32'h0, rv);
            `CHK(rv & m, e, "bus read")
        end
    endtask

    task regc(input [4:0] n, input c, input [31:0] e);
        begin
            rd_num <= n;
            rd_cmp <= c;
            repeat (2) @(posedge clk);
            `CHK(rda, e, "read port a")
            `CHK(rdb, e, "read port b")
        end
    endtask

    task g(input [9:0] f);
        go(f, 32'h0, 5'h00, 32'h0);
    endtask

    // Retire one and track expected pc and mode
    task go(input [9:0] f, input [31:0] v, input [4:0] n,
            input [31:0] d);
        reg [31:0] st;
        begin
            st = f[0] ? 32'h2 : 32'h4;
            if (f[9]) begin
                epc = (pc_e & ~32'h1) | {31'h0, isa_e};
                pc_e = 32'h80000180;
                isa_e = 1'b0;
                pend = 1'b0;
            end else begin
                if (f[3])
                    lnk = ((pc_e + (st << 1)) & ~32'h1) | {31'h0, isa_e};
                if (pend) begin
                    pc_e = tgt & ~32'h1;
                    isa_e = tgt[0];
                end else
                    pc_e = pc_e + st;
                pend = f[2];
                tgt = v;
            end
            src.ret(f, v, n, d);
            `CHK(pc, pc_e, "pc")
            `CHK(isa, isa_e, "instr_set_select")
        end
    endtask

    initial begin
        #500000;
        num_errors++;
        close_out;
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(pc, 32'hbfc00000, "reset pc")
        `CHK(mem_big, 1'b1, "mem endian")
        `CHK(ls_big, 1'b1, "ls endian")
        rdc(32'h0c, 32'hffffffff, 32'h0);
        g(F_CMP);
        g(10'h000);
        go(F_WEN, 32'h0, 5'h05, 32'h12345678);
        go(F_WEN, 32'h0, 5'h00, 32'hdeadbeef);
        regc(5'h00, 1'b0, 32'h0);
        go(F_WEN | F_WCM, 32'h0, 5'h00, 32'h16161616);
        regc(5'h10, 1'b0, 32'h16161616);
        regc(5'h00, 1'b1, 32'h16161616);
        go(F_WEN | F_WCM, 32'h0, 5'h03, 32'h33333333);
        regc(5'h03, 1'b0, 32'h33333333);
        xfer(32'h04, 1'b1, 32'h1, rv);
        go(F_WEN, 32'h0, 5'h05, 32'h55555555);
        regc(5'h05, 1'b0, 32'h55555555);
        xfer(32'h04, 1'b1, 32'h0, rv);
        regc(5'h05, 1'b0, 32'h12345678);
        go(F_WEN, 32'h0, 5'h06, 32'h11);
        go(F_WEN | F_LATE, 32'h0, 5'h06, 32'h22);
        regc(5'h06, 1'b0, 32'h11);
        g(10'h000);
        regc(5'h06, 1'b0, 32'h22);
        go(F_BR | F_PCS | F_LNK, 32'h9abc1001, 5'h00, 32'h0);
        `CHK(slot, 1'b1, "slot flag")
        g(10'h000);
        `CHK(slot, 1'b0, "slot flag")
        g(F_CMP);
        regc(5'h1f, 1'b0, lnk);
        rdc(32'h14, 32'hffffffff, lnk);
        g(F_LL);
        `CHK(link, 1'b1, "link flag")
        go(F_WEN, 32'h0, 5'h07, 32'h70);
        go(F_EXC | F_WEN, 32'h0, 5'h07, 32'h77);
        `CHK(exc, 1'b1, "exc pulse")
        `CHK(exc_type, 5'h07, "exc type")
        `CHK(exc_arg, 32'h77, "exc arg")
        `CHK(exc_epc, epc, "epc")
        `CHK(link, 1'b0, "link flag")
        regc(5'h07, 1'b0, 32'h70);
        g(F_LL);
        g(F_SC);
        `CHK(sc_ok, 1'b1, "sc ok")
        `CHK(link, 1'b0, "link flag")
        g(F_LL);
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
        @(posedge clk);
        `CHK(link, 1'b0, "link flag")
        g(F_SC);
        `CHK(sc_ok, 1'b0, "sc ok")
        rdc(32'h08, 32'h3, 32'h3);
        `CHK(irq, 1'b0, "masked irq")
        xfer(32'h0c, 1'b1, 32'h2, rv);
        @(posedge clk);
        `CHK(irq, 1'b1, "irq")
        xfer(32'h08, 1'b1, 32'h2, rv);
        @(posedge clk);
        `CHK(irq, 1'b0, "cleared irq")
        rdc(32'h08, 32'h3, 32'h1);
        xfer(32'h3c, 1'b1, 32'hffffffff, rv);
        rdc(32'h3c, 32'hffffffff, 32'h0);
        xfer(32'h00, 1'b1, 32'h3, rv);
        repeat (2) @(posedge clk);
        `CHK(flip, 1'b0, "flip in kernel")
        `CHK(ls_big, 1'b1, "ls endian")
        `CHK(wide, 1'b1, "fpr width")
        user <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(flip, 1'b1, "flip in user")
        `CHK(ls_big, 1'b0, "ls endian")
        rdc(32'h1c, 32'h7, 32'h5);
        user <= 1'b0;
        xfer(32'h00, 1'b1, 32'h0, rv);
        repeat (2) @(posedge clk);
        `CHK(wide, 1'b0, "fpr width")
        `CHK(flip, 1'b0, "flip off")
        fcc <= 8'ha5;
        repeat (2) @(posedge clk);
        `CHK(fcc_o, 8'ha4, "fcc")
        fcc <= 8'h5a;
        cop <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(fcc_o, 8'h5b, "fcc")
        rst <= 1'b1;
        strap <= 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(pc, 32'hbfc00000, "pc after reset")
        `CHK(mem_big, 1'b0, "mem endian")
        pc_e = 32'hbfc00000;
        isa_e = 1'b0;
        pend = 1'b0;
        g(10'h000);
        close_out;
    end
endmodule // test_casx_core_state
